// ---- jbc_jitter_ecc.sv ----
// Jitter buffer with C1/C2 flag processing, plus its output FIFO.
// Assumes an external syndrome unit that classifies each codeword sent
// on cw_sym_out and answers with class, positions and error values.
//
// Operation
// - Hold symbols in 2048 x 8 RAM
// - Keep write position steered toward buffer centre
// - Divisor 588 centre, 589 behind, 587 ahead
// - Four frames off centre forces recentring
// - Mute output 128 frames after recentring
// - Run C1 then C2, write back to RAM
// - Zero or one error: correct, clear flags
// - C1 two errors: correct, set flags
// - C1 three or more: no correction, set flags
// - C2 two matched: correct, unless seven flags
// - C2 one matched: set if five, else copy
// - C2 none matched: set if two, else copy
// - C2 three or more: set if two, else copy
`timescale 1ns/1ps

module jbc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Async reset, high
  input wire logic in_valid_in, // Write request
  output logic in_ready_out, // Room available
  input wire logic [WIDTH-1:0] in_data_in, // Write data
  output logic out_valid_out, // Data available
  input wire logic out_ready_in, // Reader takes word
  output logic [WIDTH-1:0] out_data_out // Head word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  logic [PW:0] cnt_next;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
  assign out_data_out = mem_reg[rp_reg];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      out_valid_out <= 1'b0;
      in_ready_out <= 1'b1;
    end else begin
      if (push) wp_reg <= PW'((wp_reg + 1'b1) % DEPTH);
      if (pop) rp_reg <= PW'((rp_reg + 1'b1) % DEPTH);
      cnt_reg <= cnt_next;
      out_valid_out <= cnt_next != '0;
      in_ready_out <= cnt_next != (PW+1)'(DEPTH);
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) mem_reg[wp_reg] <= in_data_in;
  end

  chk_fifo_no_overrun: assert property (@(posedge clk_in) disable iff
    (rst_in) cnt_reg <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule : jbc_fifo

module jbc_jitter_ecc
  import jbc_pkg::*;
#(
  parameter int DEPTH = jbc_pkg::FIFO_DEPTH
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Async reset, high
  input wire logic [jbc_pkg::SYM_W-1:0] sym_in, // Demodulated symbol
  input wire logic sym_valid_in, // Symbol strobe
  input wire logic frame_start_in, // Written frame boundary
  input wire logic frame_tick_in, // Crystal frame timing
  output logic [jbc_pkg::SYM_W-1:0] cw_sym_out, // Codeword symbol
  output logic cw_valid_out, // Codeword symbol strobe
  output logic cw_c2_out, // Codeword is a C2 word
  input wire logic synd_valid_in, // Syndrome answer strobe
  input wire jbc_pkg::jbc_err_type synd_class_in, // Error count class
  input wire logic [jbc_pkg::IDX_W-1:0] synd_pos_a_in, // First position
  input wire logic [jbc_pkg::IDX_W-1:0] synd_pos_b_in, // Second position
  input wire logic [jbc_pkg::SYM_W-1:0] synd_val_a_in, // First value
  input wire logic [jbc_pkg::SYM_W-1:0] synd_val_b_in, // Second value
  output logic [jbc_pkg::DIV_W-1:0] divisor_out, // CLV divisor
  output logic mute_out, // Output muting
  output logic [jbc_pkg::SYM_W-1:0] out_sym_out, // Output symbol
  output logic out_flag_out, // Final C2 flag
  output logic out_valid_out, // Output strobe
  input wire logic out_ready_in // Downstream accepts
);
  import jbc_pkg::*;

  // ********************************************************
  // Storage and state
  // ********************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEND, ST_WAIT, ST_FIX, ST_OUT
  } jbc_state_type;

  logic [SYM_W-1:0] ram_reg [RAM_DEPTH];
  logic flag_reg [RAM_DEPTH];
  jbc_state_type state_reg;
  logic c2_reg;
  logic [CNT_W-1:0] idx_reg;
  logic [CNT_W-1:0] nfl_reg;
  logic [FR_W-1:0] wr_frame_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [FR_W-1:0] rd_frame_reg;
  logic tick_pend_reg;
  logic fix_reg;
  jbc_act_type act_reg;
  jbc_err_type cls_reg;
  logic [IDX_W-1:0] pa_reg;
  logic [IDX_W-1:0] pb_reg;
  logic [SYM_W-1:0] va_reg;
  logic [SYM_W-1:0] vb_reg;
  logic [MUTE_W-1:0] mute_cnt_reg;
  logic [MUTE_W-1:0] mute_cnt_next;
  logic fifo_ready;

  // Flag decision: {correct, flag action}
  function automatic logic [2:0] decide(input logic c2,
      input jbc_err_type cls, input logic [1:0] hits,
      input logic [CNT_W-1:0] nfl);
    logic [2:0] r;
    r = {1'b1, FL_CLEAR};
    case (cls)
      ERR_NONE, ERR_ONE: r = {1'b1, FL_CLEAR};
      ERR_TWO: begin
        if (!c2) begin
          r = {1'b1, FL_SET};
        end else if (hits == 2'd2) begin
          r = (nfl >= C2_BOTH_COPY) ? {1'b0, FL_COPY}
                                    : {1'b1, FL_CLEAR};
        end else if (hits == 2'd1) begin
          r = (nfl <= C2_ONE_SET) ? {1'b0, FL_SET}
                                  : {1'b0, FL_COPY};
        end else begin
          r = (nfl <= C2_NONE_SET) ? {1'b0, FL_SET}
                                   : {1'b0, FL_COPY};
        end
      end
      default: begin
        if (!c2) begin
          r = {1'b0, FL_SET};
        end else begin
          r = (nfl <= C2_NONE_SET) ? {1'b0, FL_SET}
                                   : {1'b0, FL_COPY};
        end
      end
    endcase
    return r;
  endfunction : decide

  // ********************************************************
  // Write side and position steering
  // ********************************************************
  wire [FR_W-1:0] diff = FR_W'(wr_frame_reg - rd_frame_reg);
  wire signed [FR_W-1:0] pos = $signed(FR_W'(diff - CENTER_FRAMES));
  wire recentre = frame_start_in && (pos >= POS_LIMIT || pos <= -POS_LIMIT);
  wire [DIV_W-1:0] div_sel = (pos > 0) ? DIV_FAST :
                             (pos < 0) ? DIV_SLOW : DIV_CENTER;
  wire [ADDR_W-1:0] wr_addr = {wr_frame_reg, wr_idx_reg};

  assign mute_cnt_next = recentre ? MUTE_FRAMES :
      (frame_tick_in && mute_cnt_reg != '0) ? mute_cnt_reg - 1'b1
                                            : mute_cnt_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_frame_reg <= CENTER_FRAMES;
      wr_idx_reg <= '0;
      divisor_out <= DIV_CENTER;
      mute_cnt_reg <= '0;
      mute_out <= 1'b0;
    end else begin
      if (frame_start_in) begin
        wr_idx_reg <= '0;
        wr_frame_reg <= recentre ? FR_W'(rd_frame_reg + CENTER_FRAMES)
                                 : FR_W'(wr_frame_reg + 1'b1);
        divisor_out <= recentre ? DIV_CENTER : div_sel;
      end else if (sym_valid_in) begin
        wr_idx_reg <= wr_idx_reg + 1'b1;
      end
      mute_cnt_reg <= mute_cnt_next;
      mute_out <= mute_cnt_next != '0;
    end
  end

  // ********************************************************
  // Correction engine
  // ********************************************************
  wire [ADDR_W-1:0] rd_addr = {rd_frame_reg, idx_reg[IDX_W-1:0]};
  wire [CNT_W-1:0] cw_len = c2_reg ? C2_LEN : C1_LEN;
  wire last = idx_reg == cw_len - 1'b1;
  wire [ADDR_W-1:0] addr_a = {rd_frame_reg, synd_pos_a_in};
  wire [ADDR_W-1:0] addr_b = {rd_frame_reg, synd_pos_b_in};
  wire [1:0] hits = 2'(flag_reg[addr_a]) + 2'(flag_reg[addr_b]);
  wire [2:0] dec = decide(c2_reg, synd_class_in, hits, nfl_reg);
  wire hit_a = fix_reg && cls_reg != ERR_NONE
               && idx_reg[IDX_W-1:0] == pa_reg;
  wire hit_b = fix_reg && cls_reg == ERR_TWO
               && idx_reg[IDX_W-1:0] == pb_reg;
  wire [SYM_W-1:0] fixed_sym = ram_reg[rd_addr]
      ^ (hit_a ? va_reg : '0) ^ (hit_b ? vb_reg : '0);
  wire fixed_flag = (act_reg == FL_SET) ||
      (act_reg == FL_COPY && flag_reg[rd_addr]);
  wire wb_en = state_reg == ST_FIX;
  wire push = state_reg == ST_OUT && fifo_ready;

  always_ff @(posedge clk_in) begin
    if (sym_valid_in && !frame_start_in) begin
      ram_reg[wr_addr] <= sym_in;
      flag_reg[wr_addr] <= 1'b0;
    end
    if (wb_en) begin
      ram_reg[rd_addr] <= fixed_sym;
      flag_reg[rd_addr] <= fixed_flag;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      c2_reg <= 1'b0;
      idx_reg <= '0;
      nfl_reg <= '0;
      rd_frame_reg <= '0;
      tick_pend_reg <= 1'b0;
      fix_reg <= 1'b0;
      act_reg <= FL_CLEAR;
      cls_reg <= ERR_NONE;
      pa_reg <= '0;
      pb_reg <= '0;
      va_reg <= '0;
      vb_reg <= '0;
      cw_sym_out <= '0;
      cw_valid_out <= 1'b0;
      cw_c2_out <= 1'b0;
    end else begin
      cw_valid_out <= 1'b0;
      if (frame_tick_in) tick_pend_reg <= 1'b1;
      case (state_reg)
        ST_IDLE: begin
          if (tick_pend_reg || frame_tick_in) begin
            // A tick landing while a pending one is consumed stays pending
            tick_pend_reg <= tick_pend_reg && frame_tick_in;
            c2_reg <= 1'b0;
            idx_reg <= '0;
            nfl_reg <= '0;
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          cw_sym_out <= ram_reg[rd_addr];
          cw_valid_out <= 1'b1;
          cw_c2_out <= c2_reg;
          nfl_reg <= nfl_reg + CNT_W'(flag_reg[rd_addr]);
          idx_reg <= last ? '0 : idx_reg + 1'b1;
          if (last) state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (synd_valid_in) begin
            fix_reg <= dec[2];
            act_reg <= jbc_act_type'(dec[1:0]);
            cls_reg <= synd_class_in;
            pa_reg <= synd_pos_a_in;
            pb_reg <= synd_pos_b_in;
            va_reg <= synd_val_a_in;
            vb_reg <= synd_val_b_in;
            state_reg <= ST_FIX;
          end
        end
        ST_FIX: begin
          idx_reg <= last ? '0 : idx_reg + 1'b1;
          if (last) begin
            nfl_reg <= '0;
            c2_reg <= 1'b1;
            state_reg <= c2_reg ? ST_OUT : ST_SEND;
          end
        end
        ST_OUT: begin
          if (push) begin
            idx_reg <= last ? '0 : idx_reg + 1'b1;
            if (last) begin
              rd_frame_reg <= rd_frame_reg + 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ********************************************************
  // Output FIFO
  // ********************************************************
  jbc_fifo #(.WIDTH(SYM_W + 1), .DEPTH(DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .in_data_in({flag_reg[rd_addr], ram_reg[rd_addr]}),
    .out_valid_out(out_valid_out),
    .out_ready_in(out_ready_in),
    .out_data_out({out_flag_out, out_sym_out})
  );

  // ********************************************************
  // Checks
  // ********************************************************
  chk_div_centre_pos: assert property (@(posedge clk_in)
    disable iff (rst_in) frame_start_in && pos == 0
    |=> divisor_out == DIV_CENTER)
    else $error("centre divisor wrong");
  chk_div_behind_pos: assert property (@(posedge clk_in)
    disable iff (rst_in) frame_start_in && pos < 0 && pos > -POS_LIMIT
    |=> divisor_out == DIV_SLOW)
    else $error("behind divisor wrong");
  chk_div_ahead_pos: assert property (@(posedge clk_in)
    disable iff (rst_in) frame_start_in && pos > 0 && pos < POS_LIMIT
    |=> divisor_out == DIV_FAST)
    else $error("ahead divisor wrong");
  chk_recentre_write_pos: assert property (@(posedge clk_in)
    disable iff (rst_in) recentre
    |=> wr_frame_reg == FR_W'($past(rd_frame_reg) + CENTER_FRAMES))
    else $error("recentre did not reach centre");
  chk_mute_after_recentre: assert property (@(posedge clk_in)
    disable iff (rst_in) recentre
    |=> mute_out && mute_cnt_reg == MUTE_FRAMES)
    else $error("no mute after recentre");
  chk_mute_ends_zero: assert property (@(posedge clk_in)
    disable iff (rst_in) mute_cnt_reg == 8'h01 && frame_tick_in
    && !recentre |=> !mute_out)
    else $error("mute outlasts count");
  chk_c1_two_set: assert property (@(posedge clk_in)
    disable iff (rst_in) state_reg == ST_WAIT && synd_valid_in
    && !c2_reg && synd_class_in == ERR_TWO
    |=> fix_reg && act_reg == FL_SET)
    else $error("c1 dual error handling wrong");
  chk_c1_many_set: assert property (@(posedge clk_in)
    disable iff (rst_in) state_reg == ST_WAIT && synd_valid_in
    && !c2_reg && synd_class_in == ERR_MANY
    |=> !fix_reg && act_reg == FL_SET)
    else $error("c1 multi error handling wrong");
  chk_c2_many_copy: assert property (@(posedge clk_in)
    disable iff (rst_in) state_reg == ST_WAIT && synd_valid_in
    && c2_reg && synd_class_in == ERR_MANY && nfl_reg > C2_NONE_SET
    |=> !fix_reg && act_reg == FL_COPY)
    else $error("c2 multi error copy wrong");
  chk_c2_both_fix: assert property (@(posedge clk_in)
    disable iff (rst_in) state_reg == ST_WAIT && synd_valid_in
    && c2_reg && synd_class_in == ERR_TWO && hits == 2'd2
    && nfl_reg < C2_BOTH_COPY |=> fix_reg && act_reg == FL_CLEAR)
    else $error("c2 matched pair not corrected");
endmodule : jbc_jitter_ecc

// ---- jbc_pkg.sv ----
// Constants and types for the jitter buffer and error-correction block.
// Assumes one 100 MHz clock; all frame timing arrives as strobes.
package jbc_pkg;

  // ********************************************************
  // Buffer geometry
  // ********************************************************
  localparam int SYM_W = 8;
  localparam int RAM_DEPTH = 2048;
  localparam int ADDR_W = 11;
  localparam int IDX_W = 5;
  localparam int FR_W = 6;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] C1_LEN = 6'h20;
  localparam logic [CNT_W-1:0] C2_LEN = 6'h1C;
  localparam logic [FR_W-1:0] CENTER_FRAMES = 6'h20;
  localparam int FIFO_DEPTH = 8;

  // ********************************************************
  // Write position steering
  // ********************************************************
  localparam logic signed [FR_W-1:0] POS_LIMIT = 6'sh04;
  localparam int DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_CENTER = 10'h24C;
  localparam logic [DIV_W-1:0] DIV_SLOW = 10'h24D;
  localparam logic [DIV_W-1:0] DIV_FAST = 10'h24B;
  localparam int MUTE_W = 8;
  localparam logic [MUTE_W-1:0] MUTE_FRAMES = 8'h80;

  // ********************************************************
  // Flag processing thresholds
  // ********************************************************
  localparam logic [CNT_W-1:0] C2_BOTH_COPY = 6'h07;
  localparam logic [CNT_W-1:0] C2_ONE_SET = 6'h05;
  localparam logic [CNT_W-1:0] C2_NONE_SET = 6'h02;

  typedef enum logic [1:0] {
    ERR_NONE, ERR_ONE, ERR_TWO, ERR_MANY
  } jbc_err_type;

  typedef enum logic [1:0] {
    FL_CLEAR, FL_SET, FL_COPY
  } jbc_act_type;

endpackage : jbc_pkg

// ---- jbc_far_model.sv ----
// Far-side model: syndrome unit answering each codeword, and the sink.
// Assumes the codeword and output ports of the jitter/ECC block.
`timescale 1ns/1ps
module jbc_far_model
  import jbc_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Async reset, high
  input wire logic [jbc_pkg::SYM_W-1:0] cw_sym_in, // Codeword symbol
  input wire logic cw_valid_in, // Symbol strobe
  input wire logic cw_c2_in, // C2 word
  input wire logic [27:0] cmd_c1_in, // Answer for C1 words
  input wire logic [27:0] cmd_c2_in, // Answer for C2 words
  input wire logic slow_in, // Answer late
  input wire logic stall_in, // Sink holds off
  output logic synd_valid_out, // Answer strobe
  output jbc_pkg::jbc_err_type synd_class_out, // Error class
  output logic [jbc_pkg::IDX_W-1:0] synd_pos_a_out, // First position
  output logic [jbc_pkg::IDX_W-1:0] synd_pos_b_out, // Second position
  output logic [jbc_pkg::SYM_W-1:0] synd_val_a_out, // First value
  output logic [jbc_pkg::SYM_W-1:0] synd_val_b_out, // Second value
  output logic out_ready_out // Sink ready
);
  logic [27:0] cmd_reg;
  logic [27:0] shown;
  logic [SYM_W-1:0] cap2_reg [0:31];
  logic [4:0] idx_reg;
  logic [4:0] wait_reg;
  logic prev_reg;
  logic c2_reg;
  logic sv_reg;
  // Outside the answer cycle the lines show the inverse of the last answer
  assign shown = sv_reg ? cmd_reg : ~cmd_reg;
  assign synd_valid_out = sv_reg;
  assign synd_class_out = jbc_err_type'(shown[27:26]);
  assign synd_pos_a_out = shown[25:21];
  assign synd_pos_b_out = shown[20:16];
  assign synd_val_a_out = shown[15:8];
  assign synd_val_b_out = shown[7:0];
  assign out_ready_out = !stall_in;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_reg <= 5'h0;
      wait_reg <= 5'h0;
      prev_reg <= 1'b0;
      c2_reg <= 1'b0;
      sv_reg <= 1'b0;
      cmd_reg <= 28'h000_0000;
    end else begin
      sv_reg <= 1'b0;
      prev_reg <= cw_valid_in;
      if (cw_valid_in) begin
        idx_reg <= idx_reg + 5'h1;
        c2_reg <= cw_c2_in;
        if (cw_c2_in) cap2_reg[idx_reg] <= cw_sym_in;
      end
      if (prev_reg && !cw_valid_in) begin
        idx_reg <= 5'h0;
        wait_reg <= slow_in ? 5'h14 : 5'h1;
      end else if (wait_reg != 5'h0) begin
        wait_reg <= wait_reg - 5'h1;
        if (wait_reg == 5'h1) begin
          sv_reg <= 1'b1;
          cmd_reg <= c2_reg ? cmd_c2_in : cmd_c1_in;
        end
      end
    end
  end
endmodule : jbc_far_model

// ---- test_jitter_buffer_error_correction.sv ----
// Self-checking bench for the jitter buffer and C1/C2 flag processing.
// Assumes jbc_pkg, jbc_jitter_ecc and jbc_far_model are compiled first.
`timescale 1ns/1ps
module test_jitter_buffer_error_correction;
  import jbc_pkg::*;
  logic clk_in, rst_in, sym_valid_in, frame_start_in, frame_tick_in;
  logic [SYM_W-1:0] sym_in, cw_sym, out_sym, val_a, val_b;
  logic cw_valid, cw_c2, synd_valid, out_flag, out_valid, out_ready;
  logic mute, slow, stall;
  jbc_err_type synd_class;
  logic [IDX_W-1:0] pos_a, pos_b;
  logic [DIV_W-1:0] divisor;
  logic [27:0] cmd1, cmd2;
  logic [8:0] q [$];
  int bad_count, total_checks;
  int cw_count, c2_count;

  jbc_jitter_ecc #(.DEPTH(8)) jbc_jitter_ecc_inst (
    .clk_in(clk_in), .rst_in(rst_in), .sym_in(sym_in),
    .sym_valid_in(sym_valid_in), .frame_start_in(frame_start_in),
    .frame_tick_in(frame_tick_in), .cw_sym_out(cw_sym),
    .cw_valid_out(cw_valid), .cw_c2_out(cw_c2),
    .synd_valid_in(synd_valid), .synd_class_in(synd_class),
    .synd_pos_a_in(pos_a), .synd_pos_b_in(pos_b),
    .synd_val_a_in(val_a), .synd_val_b_in(val_b),
    .divisor_out(divisor), .mute_out(mute), .out_sym_out(out_sym),
    .out_flag_out(out_flag), .out_valid_out(out_valid),
    .out_ready_in(out_ready));
  jbc_far_model far_model_inst (
    .clk_in(clk_in), .rst_in(rst_in), .cw_sym_in(cw_sym),
    .cw_valid_in(cw_valid), .cw_c2_in(cw_c2), .cmd_c1_in(cmd1),
    .cmd_c2_in(cmd2), .slow_in(slow), .stall_in(stall),
    .synd_valid_out(synd_valid), .synd_class_out(synd_class),
    .synd_pos_a_out(pos_a), .synd_pos_b_out(pos_b),
    .synd_val_a_out(val_a), .synd_val_b_out(val_b),
    .out_ready_out(out_ready));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      q.push_back({out_flag, out_sym});
    end
    if (cw_valid === 1'b1) cw_count++;
    if (cw_valid === 1'b1 && cw_c2 === 1'b1) c2_count++;
  end

  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic pulse_fs;
    frame_start_in = 1'b1;
    step(1);
    frame_start_in = 1'b0;
  endtask : pulse_fs
  task automatic tick;
    frame_tick_in = 1'b1;
    step(1);
    frame_tick_in = 1'b0;
  endtask : tick
  task automatic wait_outs;
    int i;
    i = 0;
    while (q.size() < 28 && i < 3000) begin
      step(1);
      i++;
    end
    check("output count", 16'(q.size()), 16'h001C);
  endtask : wait_outs
  function automatic logic [27:0] cw(input jbc_err_type c,
      input logic [4:0] pa, pb, input logic [7:0] va, vb);
    return {c, pa, pb, va, vb};
  endfunction : cw
  function automatic logic [7:0] fix(input int k, input logic [27:0] c,
      input logic [1:0] ap);
    fix = 8'h00;
    if (ap[0] && k == c[25:21]) fix = c[15:8];
    if (ap[1] && k == c[20:16]) fix ^= c[7:0];
  endfunction : fix
  task automatic run_ecc(input logic [27:0] c1, c2, input logic [1:0] a1,
      a2, input logic fl, input int hold);
    cmd1 = c1;
    cmd2 = c2;
    q.delete();
    cw_count = 0;
    c2_count = 0;
    pulse_fs;
    tick;
    if (hold > 0) begin
      stall = 1'b1;
      step(hold);
      check("full fifo valid", out_valid, 1'b1);
      check("held words", 16'(q.size()), 16'h0000);
      stall = 1'b0;
    end
    wait_outs;
    check("codeword symbols", 16'(cw_count), 16'h003C);
    check("c2 symbols", 16'(c2_count), 16'h001C);
    for (int k = 0; k < 28; k++) begin
      check("out symbol", q[k][7:0],
        (8'h10 + 8'(k)) ^ fix(k, c1, a1) ^ fix(k, c2, a2));
      check("out flag", q[k][8], fl);
    end
  endtask : run_ecc

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic test_reset;
    check("reset divisor", divisor, 10'h24C);
    check("reset mute", mute, 1'b0);
    check("reset valid", out_valid, 1'b0);
  endtask : test_reset
  task automatic fill_ram;
    for (int f = 0; f < 64; f++) begin
      pulse_fs;
      for (int k = 0; k < 32; k++) begin
        sym_in = 8'h10 + 8'(k);
        sym_valid_in = 1'b1;
        step(1);
      end
      sym_valid_in = 1'b0;
      tick;
      wait_outs;
      q.delete();
    end
    check("centred divisor", divisor, 10'h24C);
  endtask : fill_ram
  task automatic test_clean;
    run_ecc(cw(ERR_NONE, 5'h0, 5'h0, 8'h00, 8'h00), 28'h000_0000,
      2'h0, 2'h0, 1'b0, 400);
  endtask : test_clean
  task automatic test_single;
    slow = 1'b1;
    run_ecc(cw(ERR_ONE, 5'h3, 5'h9, 8'h5A, 8'h77),
      cw(ERR_ONE, 5'h7, 5'h9, 8'hA5, 8'h33), 2'h1, 2'h1, 1'b0, 0);
    slow = 1'b0;
    check("c2 sees c1 fix", far_model_inst.cap2_reg[3], 8'h49);
  endtask : test_single
  task automatic test_c1_dual;
    run_ecc(cw(ERR_TWO, 5'h1, 5'h2, 8'h11, 8'h22), 28'h000_0000,
      2'h3, 2'h0, 1'b0, 0);
  endtask : test_c1_dual
  task automatic test_c2_copy;
    run_ecc(cw(ERR_TWO, 5'h1, 5'h2, 8'h11, 8'h22),
      cw(ERR_TWO, 5'h1, 5'h2, 8'h44, 8'h55), 2'h3, 2'h0, 1'b1, 0);
  endtask : test_c2_copy
  task automatic test_many;
    run_ecc(cw(ERR_MANY, 5'h0, 5'h5, 8'h66, 8'h99),
      cw(ERR_MANY, 5'h6, 5'h8, 8'h0F, 8'hF0), 2'h0, 2'h0, 1'b1, 0);
  endtask : test_many
  task automatic test_unmatched;
    run_ecc(28'h000_0000, cw(ERR_TWO, 5'h4, 5'h5, 8'h3C, 8'hC3),
      2'h0, 2'h0, 1'b1, 0);
    run_ecc(28'h000_0000, cw(ERR_MANY, 5'h4, 5'h5, 8'h3C, 8'hC3),
      2'h0, 2'h0, 1'b1, 0);
  endtask : test_unmatched
  task automatic test_steer;
    pulse_fs;
    step(1);
    check("divisor centre", divisor, 10'h24C);
    for (int p = 1; p < 4; p++) begin
      pulse_fs;
      step(1);
      check("divisor ahead", divisor, 10'h24B);
    end
    pulse_fs;
    step(1);
    check("recentre divisor", divisor, 10'h24C);
    check("mute on", mute, 1'b1);
    for (int t = 0; t < 3; t++) begin
      tick;
      wait_outs;
      q.delete();
    end
    pulse_fs;
    step(1);
    check("divisor behind", divisor, 10'h24D);
    repeat (124) begin
      tick;
      step(1);
    end
    check("mute held", mute, 1'b1);
    tick;
    step(3);
    check("mute off", mute, 1'b0);
  endtask : test_steer

  initial begin
    rst_in = 1'b1;
    sym_in = 8'h00;
    sym_valid_in = 1'b0;
    frame_start_in = 1'b0;
    frame_tick_in = 1'b0;
    cmd1 = 28'h000_0000;
    cmd2 = 28'h000_0000;
    slow = 1'b0;
    stall = 1'b0;
    bad_count = 0;
    total_checks = 0;
    repeat (8) @(posedge clk_in);
    #1 rst_in = 1'b0;
    test_reset;
    fill_ram;
    test_clean;
    test_single;
    test_c1_dual;
    test_c2_copy;
    test_many;
    test_unmatched;
    test_steer;
    tally_and_finish;
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    bad_count++;
    tally_and_finish;
  end
endmodule : test_jitter_buffer_error_correction
